//--- tcf_cfg.svh
`ifndef TCF_CFG_SVH
`define TCF_CFG_SVH

// ==========================================================================
// register map (word index on the register port)
`define TCF_NUM_CH        6
`define TCF_ADDR_CFG0     8'h00
`define TCF_ADDR_DATA0    8'h08
`define TCF_ADDR_STATUS   8'h10
`define TCF_ADDR_CJ0      8'h11
`define TCF_ADDR_CJ1      8'h12

// ==========================================================================
// configuration word fields
`define TCF_BIT_DISABLE   15
`define TCF_FMT_HI        14
`define TCF_FMT_LO        12
`define TCF_TYPE_HI       11
`define TCF_TYPE_LO       8
`define TCF_BIT_FAHR      7
`define TCF_OC_HI         6
`define TCF_OC_LO         5
`define TCF_BIT_CJD       4

// ==========================================================================
// status word fields
`define TCF_STAT_CJ_LO    0
`define TCF_STAT_OVR_LO   8

// ==========================================================================
// reset values
`define TCF_CFG_RESET     16'h0000
`define TCF_CJ_RESET      16'h00fa
`define TCF_DATA_RESET    16'h0000

// ==========================================================================
// scaling constants
`define TCF_RAW_MUL       16'hfffe
`define TCF_PID_MUL       16'h3fff
`define TCF_PCT_MUL       16'h2710
`define TCF_F_MUL         16'h0009
`define TCF_ONE           16'h0001
`define TCF_DIV_F1        16'h0005
`define TCF_DIV_F10       16'h0032
`define TCF_DIV_C10       16'h000a
`define TCF_C_OFFSET      32'h00007530
`define TCF_F_OFFSET      32'h00001388
`define TCF_OUT_C1        33'h1ffff8ad0
`define TCF_OUT_C10       33'h1fffff448
`define TCF_OUT_F1        33'h1ffffec78
`define TCF_OUT_F10       33'h1fffffe0c
`define TCF_OUT_RAW       33'h1ffff8001
`define TCF_POS_FULL      33'h000007fff
`define TCF_NEG_FULL      33'h1ffff8001

// ==========================================================================
// timing
`define TCF_DIV_LAST      5'h1f

`endif

//--- tcf_pkg.sv
package tcf_pkg;

    // ======================================================================
    // engine states
    typedef enum logic [2:0] {
        TCF_IDLE  = 3'b001,
        TCF_DIV   = 3'b010,
        TCF_STORE = 3'b100
    } tcf_state_t;

    // ======================================================================
    // configuration encodings
    typedef enum logic [2:0] {
        TCF_FMT_RAW   = 3'h0,
        TCF_FMT_ENG1  = 3'h1,
        TCF_FMT_PID   = 3'h2,
        TCF_FMT_PCT   = 3'h3,
        TCF_FMT_ENG10 = 3'h4
    } tcf_format_t;

    typedef enum logic [1:0] {
        TCF_OC_UP   = 2'h0,
        TCF_OC_DOWN = 2'h1,
        TCF_OC_LAST = 2'h2,
        TCF_OC_ZERO = 2'h3
    } tcf_oc_t;

    typedef enum logic [3:0] {
        TCF_IN_J     = 4'h0,
        TCF_IN_K     = 4'h1,
        TCF_IN_T     = 4'h2,
        TCF_IN_E     = 4'h3,
        TCF_IN_R     = 4'h4,
        TCF_IN_S     = 4'h5,
        TCF_IN_B     = 4'h6,
        TCF_IN_N     = 4'h7,
        TCF_IN_C     = 4'h8,
        TCF_IN_MV50  = 4'h9,
        TCF_IN_MV100 = 4'ha,
        TCF_IN_L     = 4'hb
    } tcf_input_t;

    // low end, high end, low end in tenths of fahrenheit
    typedef struct packed {
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic signed [15:0] loF;
    } tcf_range_t;

endpackage : tcf_pkg

//--- tcf_channel_data_formatter.sv
// Behaviour
// R01 - raw format maps range low to -32767 and high to +32767
// R02 - x1 format: tenths of a degree, hundredths of a millivolt
// R03 - x10 format: whole degrees, tenths of a millivolt
// R04 - PID format maps range onto 0 through +16383
// R05 - percent format maps range onto 0 through +10000
// R06 - input type from config bits 11..8, per channel
// R07 - bit 7 picks C or F, ignored for mV, raw, PID, percent
// R08 - x1 F on type B or C flags over-range above 3276.7 F
// R09 - bits 6..5 pick the open-circuit substitute value
// R10 - upscale option outputs full upper-scale word
// R11 - downscale option outputs full lower-scale word
// R12 - last-state option holds last valid data word
// R13 - zero option forces data word to zero
// R14 - open cold junction sets status bit, readings continue
// R15 - cold junction open from power-up uses 25 C
// R16 - cold junction opening later keeps last valid reading
// R17 - millivolt channels ignore cold junction state
// R18 - bit 4 shows cold junction temperature instead of reading
// R19 - disabled channel data word is zero
// R20 - all-zero config fields are the defaults
// R21 - open-circuit codes: 00 up, 01 down, 10 last, 11 zero
// R22 - interpolate linearly, round to nearest, saturate to limits
`timescale 1ns/100ps
`default_nettype none
`include "tcf_cfg.svh"

module tcf_channel_data_formatter (
    // clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  busAddr,
    input  wire logic [15:0] busWdata,
    input  wire logic        busWrite,
    input  wire logic        busRead,
    output logic      [15:0] busRdata,
    // channel samples, tenths of C or hundredths of mV
    input  wire logic        sampleValid,
    input  wire logic [2:0]  sampleChannel,
    input  wire logic [15:0] sampleValue,
    input  wire logic        sampleOpen,
    output logic             sampleReady,
    // cold junction sensors
    input  wire logic        cjSampleValid,
    input  wire logic        cjSampleSel,
    input  wire logic [15:0] cjSampleValue,
    input  wire logic [1:0]  cjOpenPin,
    output logic      [1:0]  cjOpenStatus
);

    // ======================================================================
    // range lookup
    function automatic tcf_pkg::tcf_range_t range_of(input logic [3:0] kind);
        tcf_pkg::tcf_range_t r;
        case (kind)
            tcf_pkg::TCF_IN_K:     r = {16'hf574, 16'h3584, 16'hee44};
            tcf_pkg::TCF_IN_T:     r = {16'hf574, 16'h0fa0, 16'hee44};
            tcf_pkg::TCF_IN_E:     r = {16'hf574, 16'h2710, 16'hee44};
            tcf_pkg::TCF_IN_R:     r = {16'h0000, 16'h4510, 16'h0140};
            tcf_pkg::TCF_IN_S:     r = {16'h0000, 16'h4510, 16'h0140};
            tcf_pkg::TCF_IN_B:     r = {16'h0bb8, 16'h4718, 16'h1658};
            tcf_pkg::TCF_IN_N:     r = {16'hf7cc, 16'h32c8, 16'hf27c};
            tcf_pkg::TCF_IN_C:     r = {16'h0000, 16'h5a6e, 16'h0140};
            tcf_pkg::TCF_IN_L:     r = {16'hf830, 16'h2328, 16'hf330};
            tcf_pkg::TCF_IN_MV50:  r = {16'hec78, 16'h1388, 16'h0000};
            tcf_pkg::TCF_IN_MV100: r = {16'hd8f0, 16'h2710, 16'h0000};
            // undefined codes fall back to the default type
            default:               r = {16'hf7cc, 16'h2ee0, 16'hf27c}; // R20
        endcase
        return r;
    endfunction : range_of

    function automatic logic is_mv(input logic [3:0] kind);
        return (kind == tcf_pkg::TCF_IN_MV50) || (kind == tcf_pkg::TCF_IN_MV100);
    endfunction : is_mv

    // ======================================================================
    // cold junction open pins: three stages, accept when last two agree
    logic [2:0] cjSync     [2];
    logic [2:0] next_cjSync[2];
    logic [1:0] next_cjOpen;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_cjsync
            always_comb begin
                next_cjSync[g] = {cjSync[g][1:0], cjOpenPin[g]};
                next_cjOpen[g] = cjOpenStatus[g];
                if (cjSync[g][1] == cjSync[g][2]) begin
                    next_cjOpen[g] = cjSync[g][2]; // R14
                end
            end
            always_ff @(posedge clock) begin
                if (rst) begin
                    cjSync[g]       <= 3'h0;
                    cjOpenStatus[g] <= 1'b0;
                end else if (ce) begin
                    cjSync[g]       <= next_cjSync[g];
                    cjOpenStatus[g] <= next_cjOpen[g];
                end
            end
        end
    endgenerate

    // ======================================================================
    // held cold junction temperatures
    logic [15:0] cjHeld     [2];
    logic [15:0] next_cjHeld[2];

    always_comb begin
        next_cjHeld = cjHeld;
        // an open sensor's samples are dropped, so the last good one stays
        if (cjSampleValid && !cjOpenStatus[cjSampleSel]) begin // R16
            next_cjHeld[cjSampleSel] = cjSampleValue;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cjHeld[0] <= `TCF_CJ_RESET; // R15
            cjHeld[1] <= `TCF_CJ_RESET; // R15
        end else if (ce) begin
            cjHeld <= next_cjHeld;
        end
    end

    // ======================================================================
    // registers and read port
    logic [15:0] cfgWord     [`TCF_NUM_CH];
    logic [15:0] next_cfgWord[`TCF_NUM_CH];
    logic [15:0] dataWord    [`TCF_NUM_CH];
    logic [5:0]  overRange;
    logic [15:0] next_rdata;
    logic [7:0]  rdIdx;

    always_comb begin
        next_cfgWord = cfgWord;
        next_rdata   = 16'h0000;
        rdIdx        = busAddr - `TCF_ADDR_DATA0;
        if (busWrite && (busAddr < 8'(`TCF_NUM_CH))) begin
            next_cfgWord[busAddr[2:0]] = busWdata; // R06
        end
        if (busRead) begin
            if (busAddr < 8'(`TCF_NUM_CH)) begin
                next_rdata = cfgWord[busAddr[2:0]];
            end else if ((busAddr >= `TCF_ADDR_DATA0) && (rdIdx < 8'(`TCF_NUM_CH))) begin
                next_rdata = dataWord[rdIdx[2:0]];
            end else if (busAddr == `TCF_ADDR_STATUS) begin
                next_rdata = 16'h0000;
                next_rdata[`TCF_STAT_CJ_LO +: 2]  = cjOpenStatus; // R14
                next_rdata[`TCF_STAT_OVR_LO +: 6] = overRange;    // R08
            end else if (busAddr == `TCF_ADDR_CJ0) begin
                next_rdata = cjHeld[0];
            end else if (busAddr == `TCF_ADDR_CJ1) begin
                next_rdata = cjHeld[1];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < `TCF_NUM_CH; i++) begin
                cfgWord[i] <= `TCF_CFG_RESET; // R20
            end
            busRdata <= 16'h0000;
        end else if (ce) begin
            cfgWord  <= next_cfgWord;
            busRdata <= next_rdata;
        end
    end

    // ======================================================================
    // setup of one conversion from the incoming sample
    logic                chOk;
    logic [2:0]          chIdx;
    logic [15:0]         cfg;
    tcf_pkg::tcf_range_t rng;
    logic                mvType;
    logic                useF;
    logic                fahrBCNow;
    logic signed [16:0]  cjUsed;
    logic signed [16:0]  xVal;
    logic [15:0]         dVal;
    logic [15:0]         mulSel;
    logic [15:0]         divSel;
    logic [31:0]         baseSel;
    logic [32:0]         outLoSel;
    logic [31:0]         numStart;

    always_comb begin
        chOk      = sampleChannel < 3'(`TCF_NUM_CH);
        chIdx     = chOk ? sampleChannel : 3'h0;
        cfg       = cfgWord[chIdx];
        rng       = range_of(cfg[`TCF_TYPE_HI:`TCF_TYPE_LO]); // R06
        mvType    = is_mv(cfg[`TCF_TYPE_HI:`TCF_TYPE_LO]);
        // units only matter for temperatures in engineering formats
        useF      = cfg[`TCF_BIT_FAHR] && !mvType &&
                    ((cfg[`TCF_FMT_HI:`TCF_FMT_LO] == tcf_pkg::TCF_FMT_ENG1) ||
                     (cfg[`TCF_FMT_HI:`TCF_FMT_LO] == tcf_pkg::TCF_FMT_ENG10)); // R07
        fahrBCNow = useF && (cfg[`TCF_FMT_HI:`TCF_FMT_LO] == tcf_pkg::TCF_FMT_ENG1) &&
                    ((cfg[`TCF_TYPE_HI:`TCF_TYPE_LO] == tcf_pkg::TCF_IN_B) ||
                     (cfg[`TCF_TYPE_HI:`TCF_TYPE_LO] == tcf_pkg::TCF_IN_C)); // R08
        // channels 0..2 sit at junction 0, 3..5 at junction 1
        cjUsed    = 17'(signed'(chIdx < 3'h3 ? cjHeld[0] : cjHeld[1]));
        if (cfg[`TCF_BIT_CJD]) begin
            xVal = cjUsed; // R18
        end else if (mvType) begin
            xVal = 17'(signed'(sampleValue)); // R17
        end else begin
            xVal = 17'(signed'(sampleValue)) + cjUsed; // R14
        end
        if (sampleOpen) begin
            xVal = (cfg[`TCF_OC_HI:`TCF_OC_LO] == tcf_pkg::TCF_OC_UP) ?
                   17'(rng.hi) : 17'(rng.lo); // R10 R11
        end
        // clamping to the range keeps every scaled format inside its limits except x1 F on types B and C
        if (xVal > 17'(rng.hi)) begin
            xVal = 17'(rng.hi); // R22
        end
        if (xVal < 17'(rng.lo)) begin
            xVal = 17'(rng.lo); // R22
        end
        dVal = 16'(xVal - 17'(rng.lo));
        case (cfg[`TCF_FMT_HI:`TCF_FMT_LO])
            tcf_pkg::TCF_FMT_ENG1: begin
                mulSel   = useF ? `TCF_F_MUL : `TCF_ONE;
                divSel   = useF ? `TCF_DIV_F1 : `TCF_ONE;
                outLoSel = useF ? `TCF_OUT_F1 : `TCF_OUT_C1; // R02
            end
            tcf_pkg::TCF_FMT_ENG10: begin
                mulSel   = useF ? `TCF_F_MUL : `TCF_ONE;
                divSel   = useF ? `TCF_DIV_F10 : `TCF_DIV_C10;
                outLoSel = useF ? `TCF_OUT_F10 : `TCF_OUT_C10; // R03
            end
            tcf_pkg::TCF_FMT_PID: begin
                mulSel   = `TCF_PID_MUL;
                divSel   = 16'(rng.hi - rng.lo);
                outLoSel = 33'h0; // R04
            end
            tcf_pkg::TCF_FMT_PCT: begin
                mulSel   = `TCF_PCT_MUL;
                divSel   = 16'(rng.hi - rng.lo);
                outLoSel = 33'h0; // R05
            end
            default: begin
                mulSel   = `TCF_RAW_MUL;
                divSel   = 16'(rng.hi - rng.lo);
                outLoSel = `TCF_OUT_RAW; // R01
            end
        endcase
        // offsets keep the dividend positive for the unsigned divider
        if (useF) begin
            baseSel = 32'(signed'(rng.loF)) + `TCF_F_OFFSET;
            baseSel = 32'(baseSel * 32'h5);
        end else if ((cfg[`TCF_FMT_HI:`TCF_FMT_LO] == tcf_pkg::TCF_FMT_ENG1) ||
                     (cfg[`TCF_FMT_HI:`TCF_FMT_LO] == tcf_pkg::TCF_FMT_ENG10)) begin
            baseSel = 32'(signed'(rng.lo)) + `TCF_C_OFFSET;
        end else begin
            baseSel = 32'h0;
        end
        numStart = 32'(dVal) * 32'(mulSel) + baseSel + 32'(divSel[15:1]); // R22
    end

    // ======================================================================
    // conversion engine: one restoring divide step per cycle
    tcf_pkg::tcf_state_t state;
    tcf_pkg::tcf_state_t next_state;
    logic [2:0]          curCh;
    logic [2:0]          next_curCh;
    logic [31:0]         num;
    logic [31:0]         next_num;
    logic [16:0]         rem;
    logic [16:0]         next_rem;
    logic [15:0]         den;
    logic [15:0]         next_den;
    logic [32:0]         outLo;
    logic [32:0]         next_outLo;
    logic [4:0]          stepCnt;
    logic [4:0]          next_stepCnt;
    logic                fahrBC;
    logic                next_fahrBC;
    logic                next_ready;
    logic [15:0]         next_dataWord[`TCF_NUM_CH];
    logic [5:0]          next_overRange;
    logic [16:0]         trial;
    logic signed [32:0]  sum;

    always_comb begin
        next_state     = state;
        next_curCh     = curCh;
        next_num       = num;
        next_rem       = rem;
        next_den       = den;
        next_outLo     = outLo;
        next_stepCnt   = stepCnt;
        next_fahrBC    = fahrBC;
        next_ready     = sampleReady;
        next_dataWord  = dataWord;
        next_overRange = overRange;
        trial          = {rem[15:0], num[31]};
        sum            = signed'(outLo) + signed'({1'b0, num});
        case (state)
            tcf_pkg::TCF_IDLE: begin
                // samples are only taken while sampleReady is high
                if (sampleValid && chOk) begin
                    next_curCh = sampleChannel;
                    if (cfg[`TCF_BIT_DISABLE]) begin
                        next_dataWord[chIdx]  = 16'h0000; // R19
                        next_overRange[chIdx] = 1'b0;
                    end else if (sampleOpen &&
                                 (cfg[`TCF_OC_HI:`TCF_OC_LO] == tcf_pkg::TCF_OC_ZERO)) begin
                        next_dataWord[chIdx]  = 16'h0000; // R13 R21
                    end else if (sampleOpen &&
                                 (cfg[`TCF_OC_HI:`TCF_OC_LO] == tcf_pkg::TCF_OC_LAST)) begin
                        next_dataWord[chIdx]  = dataWord[chIdx]; // R12 R21
                    end else begin
                        next_num     = numStart; // R09
                        next_den     = divSel;
                        next_rem     = 17'h0;
                        next_outLo   = outLoSel;
                        next_stepCnt = 5'h0;
                        next_fahrBC  = fahrBCNow;
                        next_ready   = 1'b0;
                        next_state   = tcf_pkg::TCF_DIV;
                    end
                end
            end
            tcf_pkg::TCF_DIV: begin
                if (trial >= {1'b0, den}) begin
                    next_rem = trial - {1'b0, den};
                    next_num = {num[30:0], 1'b1};
                end else begin
                    next_rem = trial;
                    next_num = {num[30:0], 1'b0};
                end
                next_stepCnt = stepCnt + 5'h1;
                if (stepCnt == `TCF_DIV_LAST) begin
                    next_state = tcf_pkg::TCF_STORE;
                end
            end
            tcf_pkg::TCF_STORE: begin
                next_overRange[curCh] = 1'b0;
                if (sum > signed'(`TCF_POS_FULL)) begin
                    next_dataWord[curCh]  = 16'(`TCF_POS_FULL); // R22
                    next_overRange[curCh] = fahrBC;             // R08
                end else if (sum < signed'(`TCF_NEG_FULL)) begin
                    next_dataWord[curCh]  = 16'(`TCF_NEG_FULL); // R22
                end else begin
                    next_dataWord[curCh]  = sum[15:0];
                end
                next_ready = 1'b1;
                next_state = tcf_pkg::TCF_IDLE;
            end
            default: begin
                next_ready = 1'b1;
                next_state = tcf_pkg::TCF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state       <= tcf_pkg::TCF_IDLE;
            curCh       <= 3'h0;
            num         <= 32'h0;
            rem         <= 17'h0;
            den         <= 16'h0;
            outLo       <= 33'h0;
            stepCnt     <= 5'h0;
            fahrBC      <= 1'b0;
            sampleReady <= 1'b1;
            overRange   <= 6'h0;
            for (int i = 0; i < `TCF_NUM_CH; i++) begin
                dataWord[i] <= `TCF_DATA_RESET;
            end
        end else if (ce) begin
            state       <= next_state;
            curCh       <= next_curCh;
            num         <= next_num;
            rem         <= next_rem;
            den         <= next_den;
            outLo       <= next_outLo;
            stepCnt     <= next_stepCnt;
            fahrBC      <= next_fahrBC;
            sampleReady <= next_ready;
            overRange   <= next_overRange;
            dataWord    <= next_dataWord;
        end
    end

endmodule : tcf_channel_data_formatter
`default_nettype wire

//--- tcf_channel_data_formatter_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcf_cfg.svh"
module tcf_channel_data_formatter_assertions (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // register port
    input wire logic [7:0]  busAddr,
    input wire logic        busRead,
    input wire logic [15:0] busRdata,
    // samples and cold junction
    input wire logic        sampleReady,
    input wire logic [1:0]  cjOpenPin,
    input wire logic [1:0]  cjOpenStatus
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ==================================================================
    // register port
    a_rdata_idle: assert property (!$past(busRead) |-> busRdata == 16'h0000)
        else $error("read data not idle");
    a_unmapped_zero: assert property ($past(busRead) && $past(busAddr) > `TCF_ADDR_CJ1
        |-> busRdata == 16'h0000) else $error("unmapped read not zero");
    a_gap_zero: assert property ($past(busRead) && $past(busAddr) inside
        {8'h06, 8'h07, 8'h0e, 8'h0f} |-> busRdata == 16'h0000) else $error("gap not zero");
    a_status_bus: assert property ($past(busRead) && $past(busAddr) == `TCF_ADDR_STATUS
        |-> busRdata[1:0] == $past(cjOpenStatus) && busRdata[7:2] == 6'h00)
        else $error("status word wrong");
    a_reset_state: assert property ($past(rst) |-> sampleReady && cjOpenStatus == 2'b00)
        else $error("state after reset wrong");
    // ==================================================================
    // engine and cold junction
    a_ready_span: assert property ($fell(sampleReady) |-> ##32 !sampleReady ##1 sampleReady)
        else $error("busy span wrong");
    a_cj_open_set: assert property ($past(cjOpenPin[0], 4) && $past(cjOpenPin[0], 3)
        && $past(cjOpenPin[0], 2) && $past(cjOpenPin[0]) |-> cjOpenStatus[0])
        else $error("open junction not flagged");
    a_cj_open_clear: assert property (!$past(cjOpenPin[0], 4) && !$past(cjOpenPin[0], 3)
        && !$past(cjOpenPin[0], 2) && !$past(cjOpenPin[0]) |-> !cjOpenStatus[0])
        else $error("closed junction flagged");
    a_cj_no_glitch: assert property ($rose(cjOpenStatus[1]) |-> $past(cjOpenPin[1], 2))
        else $error("junction flag without pin");
endmodule : tcf_channel_data_formatter_assertions
bind tcf_channel_data_formatter tcf_channel_data_formatter_assertions tcf_chk_i (
    .clock(clock), .rst(rst), .busAddr(busAddr), .busRead(busRead), .busRdata(busRdata),
    .sampleReady(sampleReady), .cjOpenPin(cjOpenPin), .cjOpenStatus(cjOpenStatus));
`default_nettype wire

//--- tcf_sample_source.sv
`timescale 1ns/100ps
`default_nettype none
module tcf_sample_source (
    // clock and handshake
    input  wire logic        clock,
    input  wire logic        sampleReady,
    // sample offer
    output var logic         sampleValid,
    output var logic  [2:0]  sampleChannel,
    output var logic  [15:0] sampleValue,
    output var logic         sampleOpen
);
    initial begin
        sampleValid = 1'b0;
        sampleChannel = 3'h0;
        sampleValue = 16'h0000;
        sampleOpen = 1'b0;
    end
    // offer held until ready is seen at an edge
    task automatic send(input logic [2:0] ch, input logic [15:0] v, input logic op);
        @(posedge clock);
        sampleValid <= 1'b1;
        sampleChannel <= ch;
        sampleValue <= v;
        sampleOpen <= op;
        do @(posedge clock); while (sampleReady !== 1'b1);
        // released value and open lines carry junk so stale values are never trusted
        sampleValid <= 1'b0;
        sampleValue <= ~v;
        sampleOpen <= ~op;
    endtask : send
endmodule : tcf_sample_source
`default_nettype wire

//--- tcf_channel_data_formatter_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcf_cfg.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, s); end end
module tcf_channel_data_formatter_bench;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  busAddr = 8'h00;
    logic [15:0] busWdata = 16'h0000;
    logic        busWrite = 1'b0;
    logic        busRead = 1'b0;
    logic [15:0] busRdata;
    logic        sampleValid, sampleOpen, sampleReady;
    logic [2:0]  sampleChannel;
    logic [15:0] sampleValue;
    logic        cjSampleValid = 1'b0;
    logic        cjSampleSel = 1'b0;
    logic [15:0] cjSampleValue = 16'h0000;
    logic [1:0]  cjOpenPin = 2'b00;
    logic [1:0]  cjOpenStatus;
    int          mismatches = 0;
    int          checked = 0;
    // type J range is -2100..12000 tenths C; junctions sit at 25.0 C after reset
    logic [15:0] tCfg [14] = '{16'h0000, 16'h0000, 16'h1000, 16'h4000, 16'h2000, 16'h2000,
        16'h3000, 16'h1080, 16'h4080, 16'h0080, 16'h1980, 16'h0000, 16'h0020, 16'h0060};
    logic [15:0] tVal [14] = '{16'hf6d2, 16'h2de6, 16'h02ee, 16'h02ee, 16'h2de6, 16'hf6d2,
        16'h2de6, 16'h02ee, 16'h02ee, 16'h2de6, 16'h04d2, 16'h02ee, 16'h02ee, 16'h02ee};
    logic [15:0] tExp [14] = '{16'h8001, 16'h7fff, 16'h03e8, 16'h0064, 16'h3fff, 16'h0000,
        16'h2710, 16'h0848, 16'h00d4, 16'h7fff, 16'h04d2, 16'h7fff, 16'h8001, 16'h0000};
    always #4 clock = ~clock;
    tcf_channel_data_formatter tcf_channel_data_formatter_i (.clock(clock), .rst(rst),
        .ce(1'b1), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
        .busRead(busRead), .busRdata(busRdata), .sampleValid(sampleValid),
        .sampleChannel(sampleChannel), .sampleValue(sampleValue), .sampleOpen(sampleOpen),
        .sampleReady(sampleReady), .cjSampleValid(cjSampleValid), .cjSampleSel(cjSampleSel),
        .cjSampleValue(cjSampleValue), .cjOpenPin(cjOpenPin), .cjOpenStatus(cjOpenStatus));
    tcf_sample_source tcf_sample_source_i (.clock(clock), .sampleReady(sampleReady),
        .sampleValid(sampleValid), .sampleChannel(sampleChannel),
        .sampleValue(sampleValue), .sampleOpen(sampleOpen));
    // ==================================================================
    // access tasks
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        busAddr <= a;
        busWdata <= d;
        busWrite <= 1'b1;
        @(posedge clock);
        busWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string n);
        @(posedge clock);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clock);
        busRead <= 1'b0;
        #1;
        `CHK(n, e, busRdata)
    endtask : rd
    task automatic samp(input logic [2:0] ch, input logic [15:0] v, input logic op);
        int n = 0;
        tcf_sample_source_i.send(ch, v, op);
        #1;
        while (sampleReady !== 1'b1 && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("ready", 1'b1, sampleReady)
    endtask : samp
    task automatic cjs(input logic s, input logic [15:0] v);
        @(posedge clock);
        cjSampleValid <= 1'b1;
        cjSampleSel <= s;
        cjSampleValue <= v;
        @(posedge clock);
        cjSampleValid <= 1'b0;
    endtask : cjs
    task automatic pins(input logic [1:0] p);
        @(posedge clock);
        cjOpenPin <= p;
        repeat (6) @(posedge clock);
        #1;
        `CHK("cjflag", p, cjOpenStatus)
    endtask : pins
    task automatic test_done;
        if (mismatches == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // ==================================================================
    // tests
    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'h00, 16'h0000, "cfg");
        rd(`TCF_ADDR_CJ0, 16'h00fa, "cj0");
        rd(8'h30, 16'h0000, "unmapped");
        rd(8'h07, 16'h0000, "gap");
        for (int i = 0; i < 14; i++) begin
            wr(8'(i % 6), tCfg[i]);
            samp(3'(i % 6), tVal[i], i > 10);
            rd(`TCF_ADDR_DATA0 + 8'(i % 6), tExp[i], "fmt");
        end
        wr(8'h01, 16'h1040);
        samp(3'h1, 16'h02ee, 1'b0);
        samp(3'h1, 16'h1234, 1'b1);
        rd(`TCF_ADDR_DATA0 + 8'h01, 16'h03e8, "last");
        wr(8'h03, 16'h1680);
        samp(3'h3, 16'h0000, 1'b1);
        rd(`TCF_ADDR_DATA0 + 8'h03, 16'h7fff, "ovr");
        rd(`TCF_ADDR_STATUS, 16'h0800, "ovrflag");
        wr(8'h03, 16'h8000);
        samp(3'h3, 16'h02ee, 1'b0);
        rd(`TCF_ADDR_DATA0 + 8'h03, 16'h0000, "dis");
        rd(`TCF_ADDR_STATUS, 16'h0000, "ovrclr");
        wr(8'h04, 16'h1010);
        samp(3'h4, 16'h0064, 1'b0);
        rd(`TCF_ADDR_DATA0 + 8'h04, 16'h00fa, "cjshow");
        cjs(1'b0, 16'h0064);
        rd(`TCF_ADDR_CJ0, 16'h0064, "cjnew");
        pins(2'b01);
        rd(`TCF_ADDR_STATUS, 16'h0001, "cjstat");
        cjs(1'b0, 16'h03e7);
        rd(`TCF_ADDR_CJ0, 16'h0064, "cjheld");
        wr(8'h00, 16'h1000);
        samp(3'h0, 16'h02ee, 1'b0);
        rd(`TCF_ADDR_DATA0, 16'h0352, "cjcomp");
        wr(8'h02, 16'h1900);
        samp(3'h2, 16'h04d2, 1'b0);
        rd(`TCF_ADDR_DATA0 + 8'h02, 16'h04d2, "mv");
        pins(2'b10);
        pins(2'b00);
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        test_done;
    end
endmodule : tcf_channel_data_formatter_bench
`default_nettype wire
